// [verilog/trig_mode_defs.svh]
// Constants of the trigger mode selection block
`ifndef TRIG_MODE_DEFS_SVH
`define TRIG_MODE_DEFS_SVH
`define TMS_OFFSET 8'h28
`define MODE_OFF 3'h0
`define MODE_SOURCE 3'h1
`define MODE_START_STOP 3'h2
`define MODE_ACCEPTOR 3'h3
`define MODE_FRONT_IN 3'h4
`define OUT_SEL_ECL0 4'h8
`define OUT_SEL_ECL1 4'h9
`define IN_SEL_ECL0 4'h9
`define IN_SEL_ECL1 4'hA
`define RESERVED_HIGH 8'hFF
`define CLK_MHZ 100
`define PULSE_NS 100
`define PULSE_CYCLES ((`PULSE_NS * `CLK_MHZ + 999) / 1000)
`endif

// [verilog/trig_mode_pkg.sv]
// Types shared by the trigger mode selection block
package trig_mode_pkg;
   // Writable configuration fields of the register
   typedef struct packed {
      logic [2:0] output_protocol_mode;
      logic [3:0] input_line_select;
      logic front_output_enable;
      logic [3:0] output_line_select;
      logic line_drive_enable;
      logic async_edge_irq_enable;
      logic sync_edge_irq_enable;
   } cfg_s;
   // Backplane trigger lines, eight TTL then two differential
   typedef struct packed {
      logic [1:0] diff;
      logic [7:0] ttl;
   } lines_s;
   // Output protocol state
   typedef enum logic [1:0] {
      PROTO_IDLE,
      PROTO_PULSE,
      PROTO_HOLD
   } proto_e;
endpackage : trig_mode_pkg

// [verilog/trigger_mode_select_logic.sv]
// Trigger mode selection register, protocol drive and edge monitor
`timescale 1ns/1ps
`include "trig_mode_defs.svh"
module trigger_mode_select_logic #(
   parameter int PULSE_CYCLES = `PULSE_CYCLES
) (
   // Clock and resets
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic soft_reset_in,
   // Register port
   input wire logic reg_write_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   output logic [15:0] reg_rdata_out,
   // Pulse bit and acknowledge register writes
   input wire logic pulse_write_in,
   input wire logic pulse_value_in,
   input wire logic async_ack_write_in,
   input wire logic sync_ack_write_in,
   // Backplane trigger lines, open drain, active low
   input wire trig_mode_pkg::lines_s line_in,
   output trig_mode_pkg::lines_s line_out,
   output trig_mode_pkg::lines_s line_oe_out,
   // Front panel pins
   input wire logic front_in,
   output logic front_out,
   // Interrupt events
   output logic irq_request_out,
   output logic trigger_irq_flag_out
);
   import trig_mode_pkg::*;

   // Timing at a glance: a register write takes effect on the edge that
   // samples it; pins pass two flip-flops, so an edge on the selected
   // line shows as an event pulse about three cycles after the pin moves.
   // Every output is registered, so each answer is one cycle late,
   // which keeps decode glitches away from the pins.
   // Stored writable fields
   cfg_s cfg;
   // Status bits, active low when an edge has been seen
   logic async_edge_armed;
   logic sync_edge_armed;
   // Two-stage synchronisers for every line and the front input
   lines_s line_meta;
   lines_s line_sync;
   logic front_meta;
   logic front_sync;
   // Previous sample of the selected input line
   logic sel_prev;
   // Output protocol machine
   proto_e proto_state;
   proto_e next_proto_state;
   logic [7:0] pulse_count;
   logic [7:0] next_pulse_count;
   // Source mode may fire once after reset, then only after a one was written
   logic pulse_ready;
   // Acceptor drive held until acknowledged
   logic acceptor_hold;
   // High for the one cycle after the input select moves to a new line
   logic sel_fresh;

   // Combined reset; soft and hard resets clear alike
   // Both are synchronous, so one OR drives every flop that has a reset
   wire logic any_reset = reset_in | soft_reset_in;
   // Register write decode
   wire logic reg_hit = reg_addr_in == `TMS_OFFSET;
   wire logic reg_wr = reg_write_in & reg_hit;
   // Field extraction from write data; bit 2 is not stored
   // Reserved write bit 2 has no flop; software writes it as zero
   wire cfg_s wr_cfg = '{
      output_protocol_mode: reg_wdata_in[15:13],
      input_line_select: reg_wdata_in[12:9],
      front_output_enable: reg_wdata_in[8],
      output_line_select: reg_wdata_in[7:4],
      line_drive_enable: reg_wdata_in[3],
      async_edge_irq_enable: reg_wdata_in[1],
      sync_edge_irq_enable: reg_wdata_in[0]
   };

   // A write that moves the input select to another line
   wire logic sel_change = reg_wr &
      (wr_cfg.input_line_select != cfg.input_line_select);

   // Input select decode; reserved codes select nothing
   // Codes 1000, 1011 and 11xx fall through to the idle level
   wire logic in_ttl = cfg.input_line_select[3] == 1'b0;
   wire logic in_ecl0 = cfg.input_line_select == `IN_SEL_ECL0;
   wire logic in_ecl1 = cfg.input_line_select == `IN_SEL_ECL1;
   wire logic in_valid = in_ttl | in_ecl0 | in_ecl1;
   // Unselected line reads as released, so no edges appear
   wire logic sel_level = in_ttl ?
      line_sync.ttl[cfg.input_line_select[2:0]] :
      in_ecl0 ? line_sync.diff[0] :
      in_ecl1 ? line_sync.diff[1] : 1'b1;

   // Edges on the synchronised selected line
   // Just after a select change the history belongs to the old line, so
   // that cycle is masked; a true edge in that one cycle is missed, which
   // is the price of never reporting a phantom one
   wire logic edge_ok = in_valid & ~sel_fresh;
   wire logic sel_fall = edge_ok & sel_prev & ~sel_level;
   wire logic sel_rise = edge_ok & ~sel_prev & sel_level;

   // Edge events on armed status bits
   wire logic async_hit = sel_fall & async_edge_armed;
   wire logic sync_hit = sel_rise & sync_edge_armed;
   // Enable bits request on every matching edge
   // An armed bit and its enable on one edge still give one request
   wire logic async_req = async_hit |
      (sel_fall & cfg.async_edge_irq_enable);
   wire logic sync_req = sync_hit |
      (sel_rise & cfg.sync_edge_irq_enable);

   // Mode decode
   // Reserved codes 101 and 11x match no mode, so nothing is driven
   wire logic mode_source = cfg.output_protocol_mode == `MODE_SOURCE;
   wire logic mode_ss = cfg.output_protocol_mode == `MODE_START_STOP;
   wire logic mode_acc = cfg.output_protocol_mode == `MODE_ACCEPTOR;
   wire logic mode_front = cfg.output_protocol_mode == `MODE_FRONT_IN;

   // Pulse bit write events
   // The pulse bit is a strobe with its value; the bit itself is not kept
   wire logic pulse_zero = pulse_write_in & ~pulse_value_in;
   wire logic pulse_one = pulse_write_in & pulse_value_in;
   wire logic fire_pulse = mode_source & pulse_zero & pulse_ready;

   // Protocol asserted level, high means pull the line low
   // Front-in mode passes the synchronised pin, so it trails by two cycles
   wire logic proto_assert =
      (mode_source & (proto_state == PROTO_PULSE)) |
      (mode_ss & (proto_state == PROTO_HOLD)) |
      (mode_acc & acceptor_hold) |
      (mode_front & ~front_sync);

   // Output select decode to one of ten line positions
   // Codes 101x and 11xx leave every line released
   wire logic out_valid = ~cfg.output_line_select[3] |
      (cfg.output_line_select == `OUT_SEL_ECL0) |
      (cfg.output_line_select == `OUT_SEL_ECL1);
   wire logic [3:0] out_index = cfg.output_line_select;

   // Drive request per line position
   // Position index matches the line struct: TTL 0 to 7, then diff 0, 1;
   // at most one position can match, so two lines are never pulled
   logic [9:0] drive_sel;
   genvar g;
   generate
      for (g = 0; g < 10; g++) begin : g_drive
         // Only the selected line, only while drive is enabled
         assign drive_sel[g] = cfg.line_drive_enable & out_valid &
            (out_index == 4'(g)) & proto_assert;
      end
   endgenerate

   // Front output follows the protocol when enabled, else idles high
   // Low means asserted, the same sense as the backplane lines
   wire logic next_front = cfg.front_output_enable ?
      ~proto_assert : 1'b1;

   // Read value; reserved positions read as ones
   // Bit 2 shows the registered front pin, the level actually driven
   wire logic [15:0] read_value = {
      `RESERVED_HIGH,
      line_sync.diff[1], line_sync.diff[0],
      2'b11,
      front_sync,
      front_out,
      async_edge_armed, sync_edge_armed
   };

   // Protocol machine next state
   // Idle waits for a pulse bit write; a pulse counts down a fixed width;
   // a hold lasts until the stop write or a mode change, so a stale hold
   // never survives a change of mode. A zero written while a pulse runs
   // is not queued.
   always_comb begin
      next_proto_state = proto_state;
      next_pulse_count = pulse_count;
      case (proto_state)
         PROTO_IDLE: begin
            // A zero write starts a pulse or a hold
            if (fire_pulse) begin
               next_proto_state = PROTO_PULSE;
               next_pulse_count = 8'(PULSE_CYCLES - 1);
            end else if (mode_ss & pulse_zero) begin
               next_proto_state = PROTO_HOLD;
            end
         end
         PROTO_PULSE: begin
            // Fixed width low pulse, then back to idle
            if (pulse_count == 8'h00) begin
               next_proto_state = PROTO_IDLE;
            end else begin
               next_pulse_count = pulse_count - 8'h01;
            end
         end
         PROTO_HOLD: begin
            // A one write is the stop signal
            if (pulse_one | ~mode_ss) begin
               next_proto_state = PROTO_IDLE;
            end
         end
         default: begin
            next_proto_state = PROTO_IDLE;
         end
      endcase
   end

   // Synchronisers; first stage feeds only the second
   // No reset here: the pins settle during the reset hold anyway, and
   // a reset on the first stage would add nothing against metastability
   always_ff @(posedge clock_in) begin
      line_meta <= line_in;
      line_sync <= line_meta;
      front_meta <= front_in;
      front_sync <= front_meta;
   end

   // Configuration register
   // Fields take effect on the edge that samples the write
   always_ff @(posedge clock_in) begin
      if (any_reset) begin
         cfg <= '0;
      end else if (reg_wr) begin
         cfg <= wr_cfg;
      end
   end

   // Edge history; restarts released so reset gives no rising edge
   always_ff @(posedge clock_in) begin
      if (any_reset) begin
         sel_prev <= 1'b1;
      end else begin
         sel_prev <= sel_level;
      end
   end

   // Select change marker, cleared again on the next edge
   always_ff @(posedge clock_in) begin
      if (any_reset) begin
         sel_fresh <= 1'b0;
      end else begin
         sel_fresh <= sel_change;
      end
   end

   // Async status bit; a rearm write wins over an edge
   // An edge landing with the rearm write is dropped, not held over,
   // so software should rearm before the next edge can arrive
   always_ff @(posedge clock_in) begin
      if (any_reset) begin
         async_edge_armed <= 1'b1;
      end else if (async_ack_write_in) begin
         async_edge_armed <= 1'b1;
      end else if (async_hit) begin
         async_edge_armed <= 1'b0;
      end
   end

   // Sync status bit; cleared when the last acceptor lets go
   // The wired line only rises once every acceptor has released it,
   // so no count of acceptors is needed here
   always_ff @(posedge clock_in) begin
      if (any_reset) begin
         sync_edge_armed <= 1'b1;
      end else if (sync_ack_write_in) begin
         sync_edge_armed <= 1'b1;
      end else if (sync_hit) begin
         sync_edge_armed <= 1'b0;
      end
   end

   // Pulse rearm flag; a one write rearms, a fired pulse disarms
   // A zero then a one gives one pulse, then waits armed for the next zero
   always_ff @(posedge clock_in) begin
      if (any_reset) begin
         pulse_ready <= 1'b1;
      end else if (pulse_one) begin
         pulse_ready <= 1'b1;
      end else if (fire_pulse) begin
         pulse_ready <= 1'b0;
      end
   end

   // Acceptor drive; an edge in the ack cycle still asserts
   // Leaving acceptor mode drops the drive at once, with no ack needed
   always_ff @(posedge clock_in) begin
      if (any_reset | ~mode_acc) begin
         acceptor_hold <= 1'b0;
      end else if (sel_fall) begin
         acceptor_hold <= 1'b1;
      end else if (async_ack_write_in) begin
         acceptor_hold <= 1'b0;
      end
   end

   // Protocol machine state
   // The counter only matters in the pulse state
   always_ff @(posedge clock_in) begin
      if (any_reset) begin
         proto_state <= PROTO_IDLE;
         pulse_count <= 8'h00;
      end else begin
         proto_state <= next_proto_state;
         pulse_count <= next_pulse_count;
      end
   end

   // Registered pin drive; open drain only ever pulls low
   // Registering the enables keeps glitches of the decode off the pins,
   // at the cost of one cycle of latency on every drive change
   always_ff @(posedge clock_in) begin
      if (any_reset) begin
         line_oe_out <= '0;
         front_out <= 1'b1;
      end else begin
         line_oe_out <= drive_sel;
         front_out <= next_front;
      end
   end

   // Line output data is constant low
   // Kept as a flop so every output leaves a register
   always_ff @(posedge clock_in) begin
      line_out <= '0;
   end

   // Read data, event pulses
   // Read data trails the address by one cycle and is zero elsewhere
   // Each event pulse lasts one cycle; a flag always has its request too
   always_ff @(posedge clock_in) begin
      if (any_reset) begin
         reg_rdata_out <= 16'h0000;
         irq_request_out <= 1'b0;
         trigger_irq_flag_out <= 1'b0;
      end else begin
         reg_rdata_out <= reg_hit ? read_value : 16'h0000;
         irq_request_out <= async_req | sync_req;
         trigger_irq_flag_out <= async_hit | sync_hit;
      end
   end
endmodule : trigger_mode_select_logic

// [verification/trig_mode_monitor.sv]
// Port checker of the trigger mode selection block
`timescale 1ns/1ps
module trig_mode_monitor #(
   parameter int PULSE_CYCLES = 10
) (
   // Clock and resets
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic soft_reset_in,
   // Register port
   input wire logic reg_write_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic [15:0] reg_rdata_out,
   // Lines, pins and events
   input wire trig_mode_pkg::lines_s line_out,
   input wire trig_mode_pkg::lines_s line_oe_out,
   input wire logic front_out,
   input wire logic irq_request_out,
   input wire logic trigger_irq_flag_out
);
   import trig_mode_pkg::*;
   // Write taken by this register
   wire wr = reg_write_in && reg_addr_in == 8'h28;
   // Mode field off or reserved
   wire mode_void = reg_wdata_in[15:13] == 3'h0 || reg_wdata_in[15:13] > 3'h4;
   default clocking cb @(posedge clock_in);
   endclocking
   // Either reset clears state, so nothing is judged across it
   default disable iff (reset_in || soft_reset_in);
   property p_rd_other;
      reg_addr_in != 8'h28 |=> reg_rdata_out == 16'h0000;
   endproperty
   a_rd_other: assert property (p_rd_other) else $error("read off map");
   property p_rd_fixed;
      reg_addr_in == 8'h28 |=> reg_rdata_out[15:8] == 8'hFF &&
         reg_rdata_out[5:4] == 2'h3;
   endproperty
   a_rd_fixed: assert property (p_rd_fixed) else $error("fixed ones");
   property p_data_low;
      line_out == 10'h000;
   endproperty
   a_data_low: assert property (p_data_low) else $error("line data");
   property p_oe_single;
      $onehot0(line_oe_out);
   endproperty
   a_oe_single: assert property (p_oe_single) else $error("two lines");
   property p_flag_irq;
      trigger_irq_flag_out |-> irq_request_out;
   endproperty
   a_flag_irq: assert property (p_flag_irq) else $error("flag alone");
   property p_drive_off;
      wr && !reg_wdata_in[3] |-> ##2 line_oe_out == 10'h000;
   endproperty
   a_drive_off: assert property (p_drive_off) else $error("gated");
   property p_mode_off;
      wr && mode_void |-> ##2 line_oe_out == 10'h000;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("mode off");
   property p_sel_void;
      wr && reg_wdata_in[7:4] > 4'h9 |-> ##2 line_oe_out == 10'h000;
   endproperty
   a_sel_void: assert property (p_sel_void) else $error("bad select");
   property p_front_idle;
      wr && !reg_wdata_in[8] |-> ##2 front_out;
   endproperty
   a_front_idle: assert property (p_front_idle) else $error("front");
endmodule : trig_mode_monitor

// [verification/trig_line_partner.sv]
// Other backplane modules on the open-drain trigger lines
`timescale 1ns/1ps
module trig_line_partner (
   // Pulls commanded by the bench, device enables
   input wire trig_mode_pkg::lines_s pull_in,
   input wire trig_mode_pkg::lines_s dev_oe_in,
   // Resolved wire levels
   output trig_mode_pkg::lines_s level_out
);
   import trig_mode_pkg::*;
   // Pull-ups win unless someone pulls; acceptors assert low, release high
   assign level_out = ~(pull_in | dev_oe_in);
endmodule : trig_line_partner

// [verification/tb_top.sv]
// Self-checking bench of the trigger mode selection block
`timescale 1ns/1ps
module tb_top;
   import trig_mode_pkg::*;
   localparam int PULSE_CYCLES = 10;
   // Stimulus and observed ports
   logic clock_in = 1'b0;
   logic reset_in = 1'b1;
   logic soft_reset_in = 1'b0;
   logic reg_write_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic pulse_write_in = 1'b0;
   logic pulse_value_in = 1'b0;
   logic async_ack_write_in = 1'b0;
   logic sync_ack_write_in = 1'b0;
   logic front_in = 1'b1;
   lines_s pull = '0;
   lines_s line_in, line_out, line_oe_out;
   logic [15:0] reg_rdata_out;
   logic front_out, irq_request_out, trigger_irq_flag_out;
   int errors = 0;
   int checks = 0;
   int cycles = 0;
   trigger_mode_select_logic #(.PULSE_CYCLES(PULSE_CYCLES))
      trigger_mode_select_logic_i (.clock_in(clock_in), .reset_in(reset_in),
      .soft_reset_in(soft_reset_in), .reg_write_in(reg_write_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .pulse_write_in(pulse_write_in),
      .pulse_value_in(pulse_value_in), .async_ack_write_in(async_ack_write_in),
      .sync_ack_write_in(sync_ack_write_in), .line_in(line_in),
      .line_out(line_out), .line_oe_out(line_oe_out), .front_in(front_in),
      .front_out(front_out), .irq_request_out(irq_request_out),
      .trigger_irq_flag_out(trigger_irq_flag_out));
   trig_line_partner trig_line_partner_i (.pull_in(pull),
      .dev_oe_in(line_oe_out), .level_out(line_in));
   // Free-running 100 MHz clock
   initial begin
      forever #5 clock_in = ~clock_in;
   end
   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         finish_test();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(negedge clock_in);
   endtask : cyc
   // One-cycle strobe, then a quiet cycle so strobes never merge
   task automatic strobe(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(1);
   endtask : strobe
   task automatic pulse(input logic v);
      pulse_value_in = v;
      strobe(pulse_write_in);
   endtask : pulse
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr_in = a;
      reg_wdata_in = d;
      strobe(reg_write_in);
   endtask : wr
   task automatic rd(output logic [15:0] v);
      reg_addr_in = 8'h28;
      cyc(1);
      v = reg_rdata_out;
      reg_addr_in = 8'h00;
   endtask : rd
   // Cycles a line is driven over a 30 cycle window
   task automatic oe_len(input int idx, output int n);
      n = 0;
      repeat (30) begin
         cyc(1);
         if (line_oe_out[idx] === 1'b1) n++;
      end
   endtask : oe_len
   // Packs request and flag pulse counts as 8'h<irq><flag>
   task automatic ev(output logic [15:0] v);
      v = 16'h0000;
      repeat (10) begin
         cyc(1);
         if (irq_request_out === 1'b1) v = v + 16'h0010;
         if (trigger_irq_flag_out === 1'b1) v = v + 16'h0001;
      end
   endtask : ev
   task automatic t_status;
      logic [15:0] v;
      rd(v);
      check(v, 16'hFFFF);
      pull.diff = 2'b01;
      front_in = 1'b0;
      cyc(4);
      rd(v);
      check(v, 16'hFFB7);
      pull.diff = 2'b10;
      cyc(4);
      rd(v);
      check(v, 16'hFF77);
      pull = '0;
      front_in = 1'b1;
   endtask : t_status
   task automatic t_source;
      logic [15:0] v;
      int n;
      wr(8'h28, {3'h1, 4'h0, 1'b1, 4'h3, 1'b1, 3'h0});
      pulse(1'b0);
      cyc(3);
      check({15'h0, front_out}, 16'h0000);
      rd(v);
      check(v, 16'hFFFB);
      cyc(20);
      pulse(1'b0);
      oe_len(3, n);
      check(16'(n), 16'h0000);
      pulse(1'b1);
      // Hand strobe so the count starts on the first driven cycle
      pulse_value_in = 1'b0;
      pulse_write_in = 1'b1;
      cyc(1);
      pulse_write_in = 1'b0;
      oe_len(3, n);
      check(16'(n), 16'(PULSE_CYCLES));
   endtask : t_source
   task automatic t_start_stop;
      int n;
      wr(8'h2A, {3'h2, 4'h0, 1'b0, 4'h8, 1'b1, 3'h0});
      pulse(1'b0);
      oe_len(8, n);
      check(16'(n), 16'h0000);
      wr(8'h28, {3'h2, 4'h0, 1'b0, 4'h8, 1'b1, 3'h0});
      pulse(1'b0);
      cyc(4);
      oe_len(8, n);
      check(16'(n), 16'h001E);
      pulse(1'b1);
      cyc(4);
      check({6'h0, line_oe_out}, 16'h0000);
      pulse(1'b0);
      cyc(4);
      soft_reset_in = 1'b1;
      cyc(3);
      soft_reset_in = 1'b0;
      cyc(2);
      check({6'h0, line_oe_out}, 16'h0000);
   endtask : t_start_stop
   task automatic t_front;
      wr(8'h28, {3'h4, 4'h0, 1'b0, 4'h9, 1'b1, 3'h0});
      front_in = 1'b0;
      cyc(5);
      check({6'h0, line_oe_out}, 16'h0200);
      wr(8'h28, {3'h4, 4'h0, 1'b0, 4'hA, 1'b1, 3'h0});
      cyc(5);
      check({6'h0, line_oe_out}, 16'h0000);
      wr(8'h28, {3'h4, 4'h0, 1'b0, 4'h9, 1'b0, 3'h0});
      cyc(5);
      check({6'h0, line_oe_out}, 16'h0000);
      // Reserved mode codes must drive nothing
      wr(8'h28, {3'h5, 4'h0, 1'b0, 4'h9, 1'b1, 3'h0});
      cyc(5);
      check({6'h0, line_oe_out}, 16'h0000);
      wr(8'h28, {3'h6, 4'h0, 1'b0, 4'h9, 1'b1, 3'h0});
      cyc(5);
      check({6'h0, line_oe_out}, 16'h0000);
      front_in = 1'b1;
   endtask : t_front
   task automatic t_events;
      logic [15:0] v;
      wr(8'h28, {3'h0, 4'h5, 1'b0, 4'h0, 1'b0, 3'h3});
      pull.ttl[5] = 1'b1;
      ev(v);
      check(v, 16'h0011);
      rd(v);
      check(v, 16'hFFFD);
      pull.ttl[5] = 1'b0;
      ev(v);
      check(v, 16'h0011);
      pull.ttl[5] = 1'b1;
      ev(v);
      check(v, 16'h0010);
      pull.ttl[5] = 1'b0;
      ev(v);
      check(v, 16'h0010);
      strobe(async_ack_write_in);
      rd(v);
      check(v, 16'hFFFE);
      strobe(sync_ack_write_in);
      rd(v);
      check(v, 16'hFFFF);
   endtask : t_events
   task automatic t_acceptor;
      wr(8'h28, {3'h3, 4'h9, 1'b0, 4'h2, 1'b1, 3'h0});
      pull.diff[0] = 1'b1;
      cyc(6);
      pull.diff[0] = 1'b0;
      cyc(6);
      check({6'h0, line_oe_out}, 16'h0004);
      strobe(async_ack_write_in);
      cyc(3);
      check({6'h0, line_oe_out}, 16'h0000);
   endtask : t_acceptor
   task automatic finish_test;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test
   // Main sequence
   initial begin
      cyc(6);
      reset_in = 1'b0;
      cyc(3);
      t_status();
      t_source();
      t_start_stop();
      t_front();
      t_events();
      t_acceptor();
      finish_test();
   end
endmodule : tb_top
bind trigger_mode_select_logic trig_mode_monitor #(.PULSE_CYCLES(PULSE_CYCLES))
   trig_mode_monitor_i (.clock_in(clock_in), .reset_in(reset_in),
   .soft_reset_in(soft_reset_in), .reg_write_in(reg_write_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_rdata_out(reg_rdata_out), .line_out(line_out),
   .line_oe_out(line_oe_out), .front_out(front_out),
   .irq_request_out(irq_request_out),
   .trigger_irq_flag_out(trigger_irq_flag_out));
